//--- hw/gpp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gpp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_synced
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage is read only by the second stage
  always_comb begin
    meta_d = pin_async;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_synced = sync_q;

endmodule

`default_nettype wire

//--- hw/gpp_top.sv
// Functional notes
// - Eight-pin first port is input only, never driven.
// - First port state read always returns its current pin levels.
// - First port state register is 8-bit read-only; writes change nothing.
// - Second port has four input-only pins.
// - Second port read gives pins on bits 3..0, undefined on 7..4.
// - Second port state register is 8-bit read-only; writes ignored.
// - Third port has four pins, each input or output.
// - Direction register is write-only; reads return an undefined value.
// - Direction bit 1 drives the pin, 0 makes it input; reset 0.
// - Output data bits 3..0 are read/write, reset to 0.
// - Output pin reads back its output data bit.
// - Input pin reads back its actual pin level.
// - Third port state register is 8-bit read-only; writes ignored.
// - Input pin with pull-up bit 1 has its pull-up on.
// - Pull-up control bits 3..0 read/write, reset 0, pull-ups off.
// - Reserved bits 7..4 of data, state, pull-up read undefined.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_cfg.svh"

module gpp_top #(
  parameter int EIGHT_W = 8,
  parameter int FOUR_W  = 4,
  parameter int BIDIR_W = 4
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`GPP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Input-only ports
  input  wire logic [EIGHT_W-1:0]     in_eight_pin,
  input  wire logic [FOUR_W-1:0]      in_four_pin,
  // Bidirectional port
  input  wire logic [BIDIR_W-1:0]     bidir_pin_lvl,
  output logic      [BIDIR_W-1:0]     bidir_pin_drv,
  output logic      [BIDIR_W-1:0]     bidir_pin_oe_n,
  output logic      [BIDIR_W-1:0]     bidir_pullup_en
);

  // Pin synchronisers
  localparam int SYNC_W = EIGHT_W + FOUR_W + BIDIR_W;

  logic [SYNC_W-1:0]  pins_sync;
  logic [EIGHT_W-1:0] eight_s;
  logic [FOUR_W-1:0]  four_s;
  logic [BIDIR_W-1:0] bidir_s;

  // Input-only ports have no driver at all, only a sampling path
  gpp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_async  ({bidir_pin_lvl, in_four_pin, in_eight_pin}),
    .pin_synced (pins_sync)
  );

  assign eight_s = pins_sync[EIGHT_W-1:0];
  assign four_s  = pins_sync[EIGHT_W+FOUR_W-1:EIGHT_W];
  assign bidir_s = pins_sync[SYNC_W-1:EIGHT_W+FOUR_W];

  // Bus decode
  logic access;
  logic commit;
  logic wr_commit;
  logic hit_eight;
  logic hit_four;
  logic hit_dir;
  logic hit_out;
  logic hit_state;
  logic hit_pullup;
  logic hit_any;

  gpp_pkg::gpp_apb_state_t st_q;
  gpp_pkg::gpp_apb_state_t st_d;

  // Access phase seen, answer not yet given
  assign access     = psel && penable && (st_q == gpp_pkg::GPP_ST_IDLE);
  // Edge at which the master samples pready high
  assign commit     = psel && penable && pready;
  assign wr_commit  = commit && pwrite && !pslverr;
  assign hit_eight  = (paddr == `GPP_OFF_EIGHT_STATE);
  assign hit_four   = (paddr == `GPP_OFF_FOUR_STATE);
  assign hit_dir    = (paddr == `GPP_OFF_BIDIR_DIR);
  assign hit_out    = (paddr == `GPP_OFF_BIDIR_OUT);
  assign hit_state  = (paddr == `GPP_OFF_BIDIR_STATE);
  assign hit_pullup = (paddr == `GPP_OFF_BIDIR_PULLUP);
  assign hit_any    = hit_eight || hit_four || hit_dir || hit_out || hit_state || hit_pullup;

  // Bidirectional port control state
  logic [BIDIR_W-1:0] dir_q;
  logic [BIDIR_W-1:0] dir_d;
  logic [BIDIR_W-1:0] dout_q;
  logic [BIDIR_W-1:0] dout_d;
  logic [BIDIR_W-1:0] pcr_q;
  logic [BIDIR_W-1:0] pcr_d;
  logic [BIDIR_W-1:0] oe_n_q;
  logic [BIDIR_W-1:0] oe_n_d;
  logic [BIDIR_W-1:0] pull_q;
  logic [BIDIR_W-1:0] pull_d;
  logic [BIDIR_W-1:0] pin_view;

  always_comb begin
    dir_d  = dir_q;
    dout_d = dout_q;
    pcr_d  = pcr_q;
    // Read-only state registers have no write path here
    if (wr_commit && hit_dir) begin
      dir_d = pwdata[`GPP_FLD_BIDIR_LSB +: BIDIR_W];
    end
    if (wr_commit && hit_out) begin
      dout_d = pwdata[`GPP_FLD_BIDIR_LSB +: BIDIR_W];
    end
    if (wr_commit && hit_pullup) begin
      pcr_d = pwdata[`GPP_FLD_BIDIR_LSB +: BIDIR_W];
    end
    // Pin drivers follow the next values so pad and registers change together
    oe_n_d = ~dir_d;
    // Pull-up only on inputs, so it never fights a driven level
    pull_d = pcr_d & ~dir_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_q  <= `GPP_RST_DIR;
      dout_q <= `GPP_RST_OUT;
      pcr_q  <= `GPP_RST_PULLUP;
      oe_n_q <= `GPP_RST_OE_N;
      pull_q <= `GPP_RST_PULLUP;
    end else begin
      dir_q  <= dir_d;
      dout_q <= dout_d;
      pcr_q  <= pcr_d;
      oe_n_q <= oe_n_d;
      pull_q <= pull_d;
    end
  end

  // Pin state view, one mux per pin
  generate
    for (genvar i = 0; i < BIDIR_W; i++) begin : g_view
      assign pin_view[i] = dir_q[i] ? dout_q[i] : bidir_s[i];
    end
  endgenerate

  // APB answer
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ready_q;
  logic        ready_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rsel;

  // Undefined bits are filled with a fixed pattern, never with stale data
  always_comb begin
    rsel = `GPP_UNDEF_FILL;
    if (hit_eight) begin
      rsel[`GPP_FLD_EIGHT_LSB +: EIGHT_W] = eight_s;
    end else if (hit_four) begin
      rsel[`GPP_FLD_FOUR_LSB +: FOUR_W] = four_s;
    end else if (hit_out) begin
      rsel[`GPP_FLD_BIDIR_LSB +: BIDIR_W] = dout_q;
    end else if (hit_state) begin
      rsel[`GPP_FLD_BIDIR_LSB +: BIDIR_W] = pin_view;
    end else if (hit_pullup) begin
      rsel[`GPP_FLD_BIDIR_LSB +: BIDIR_W] = pcr_q;
    end else begin
      // Direction reads give the fill, never the stored setting
      rsel = `GPP_UNDEF_FILL;
    end
  end

  // One wait state: the answer is registered so every output is a flop
  always_comb begin
    st_d    = st_q;
    ready_d = 1'b0;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    case (st_q)
      gpp_pkg::GPP_ST_IDLE: begin
        if (access) begin
          st_d    = gpp_pkg::GPP_ST_RESP;
          ready_d = 1'b1;
          err_d   = !hit_any;
          rdata_d = (pwrite || !hit_any) ? 32'h0000_0000 : rsel;
        end
      end
      gpp_pkg::GPP_ST_RESP: begin
        st_d = gpp_pkg::GPP_ST_IDLE;
      end
      default: begin
        st_d = gpp_pkg::GPP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q    <= gpp_pkg::GPP_ST_IDLE;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q    <= st_d;
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata          = rdata_q;
  assign pready          = ready_q;
  assign pslverr         = err_q;
  assign bidir_pin_drv   = dout_q;
  assign bidir_pin_oe_n  = oe_n_q;
  assign bidir_pullup_en = pull_q;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_read(logic hit);
    access && !pwrite && hit;
  endsequence

  sequence s_write(logic hit);
    psel && penable && pready && pwrite && hit && !pslverr;
  endsequence

  sequence s_bad_write;
    psel && penable && pready && pwrite && pslverr;
  endsequence

  // Answer comes exactly one cycle after the access phase starts
  apb_answer_time_a : assert property (
    access |=> pready
  ) else $error("pready not one cycle after access");

  apb_ready_pulse_a : assert property (
    pready |=> !pready
  ) else $error("pready held longer than one cycle");

  apb_err_ready_a : assert property (
    pslverr |-> pready
  ) else $error("pslverr without pready");

  // A cycle without select can never be answered in the next one
  apb_no_spurious_a : assert property (
    !psel |=> !pready
  ) else $error("pready without a request");

  apb_write_rdata_a : assert property (
    access && pwrite |=> prdata == 32'h0000_0000
  ) else $error("write answered with read data");

  apb_unmapped_err_a : assert property (
    access && !hit_any |=> pready && pslverr && prdata == 32'h0000_0000
  ) else $error("unmapped access without error");

  eight_read_pins_a : assert property (
    s_read(hit_eight) |=> prdata[EIGHT_W-1:0] == $past(eight_s) && prdata[31:EIGHT_W] == '0
  ) else $error("first port read not the pin levels");

  four_read_pins_a : assert property (
    s_read(hit_four) |=> prdata[FOUR_W-1:0] == $past(four_s) && prdata[31:FOUR_W] == '0
  ) else $error("second port read wrong");

  ro_write_keep_a : assert property (
    s_write(hit_eight || hit_four || hit_state) |=> $stable(dir_q) && $stable(dout_q) && $stable(pcr_q)
  ) else $error("write to read-only register changed state");

  dir_read_hide_a : assert property (
    s_read(hit_dir) |=> prdata == `GPP_UNDEF_FILL
  ) else $error("direction setting leaked on read");

  dir_drive_pin_a : assert property (
    s_write(hit_dir) |=> bidir_pin_oe_n == ~$past(pwdata[BIDIR_W-1:0]) ##1 $stable(bidir_pin_oe_n)
  ) else $error("direction write did not steer the driver");

  dout_write_back_a : assert property (
    s_write(hit_out) |=> bidir_pin_drv == $past(pwdata[BIDIR_W-1:0])
  ) else $error("output data write lost");

  // Output pins read the register, so a loaded pad cannot mislead software
  state_out_mux_a : assert property (
    s_read(hit_state) |=> ((prdata[BIDIR_W-1:0] ^ $past(dout_q)) & $past(dir_q)) == '0 &&
                          prdata[31:BIDIR_W] == '0
  ) else $error("output pin state not read from data register");

  state_in_pin_a : assert property (
    s_read(hit_state) |=> ((prdata[BIDIR_W-1:0] ^ $past(bidir_s)) & ~$past(dir_q)) == '0
  ) else $error("input pin level not read back");

  pull_only_input_a : assert property (
    s_write(hit_pullup) |=> bidir_pullup_en == ($past(pwdata[BIDIR_W-1:0]) & ~dir_q)
  ) else $error("pull-up gating wrong");

  reset_values_a : assert property (@(posedge clk_sys) disable iff (1'b0)
    $past(rst) |-> dir_q == '0 && dout_q == '0 && pcr_q == '0 &&
                   bidir_pullup_en == '0 && bidir_pin_oe_n == '1
  ) else $error("reset values wrong");

  // Pad controls
  oe_follow_dir_a : assert property (
    bidir_pin_oe_n == ~dir_q
  ) else $error("driver enable differs from direction");

  pull_off_output_a : assert property (
    (bidir_pullup_en & ~bidir_pin_oe_n) == '0
  ) else $error("pull-up on while pin is driven");

  dir_write_pull_a : assert property (
    s_write(hit_dir) |=> (bidir_pullup_en & $past(pwdata[BIDIR_W-1:0])) == '0
  ) else $error("pull-up left on after pin turned output");

  pcr_read_back_a : assert property (
    s_read(hit_pullup) |=> prdata[BIDIR_W-1:0] == $past(pcr_q) && prdata[31:BIDIR_W] == '0
  ) else $error("pull-up control read wrong");

  dout_read_back_a : assert property (
    s_read(hit_out) |=> prdata[BIDIR_W-1:0] == $past(dout_q) && prdata[31:BIDIR_W] == '0
  ) else $error("output data read wrong");

  bad_write_keep_a : assert property (
    s_bad_write |=> $stable(dir_q) && $stable(dout_q) && $stable(pcr_q)
  ) else $error("refused write changed state");

  // Reads must see the pin as it stood two edges earlier, no more and no less
  sync_delay_a : assert property (
    !$past(rst) && !$past(rst, 2) |-> pins_sync == $past({bidir_pin_lvl, in_four_pin, in_eight_pin}, 2)
  ) else $error("pin synchroniser delay wrong");

endmodule

`default_nettype wire

//--- include/gpp_cfg.svh
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// Register byte offsets on the APB
`define GPP_ADDR_W            12
`define GPP_OFF_EIGHT_STATE   12'h000
`define GPP_OFF_FOUR_STATE    12'h004
`define GPP_OFF_BIDIR_DIR     12'h008
`define GPP_OFF_BIDIR_OUT     12'h00c
`define GPP_OFF_BIDIR_STATE   12'h010
`define GPP_OFF_BIDIR_PULLUP  12'h014

// Field positions
`define GPP_FLD_EIGHT_LSB     0
`define GPP_FLD_FOUR_LSB      0
`define GPP_FLD_BIDIR_LSB     0

// Reset values
`define GPP_RST_DIR           4'h0
`define GPP_RST_OUT           4'h0
`define GPP_RST_PULLUP        4'h0
`define GPP_RST_OE_N          4'hf

// Value shown by undefined and reserved read bits
`define GPP_UNDEF_FILL        32'h0000_0000

// Pin synchroniser depth
`define GPP_SYNC_STAGES       2

`endif

//--- include/gpp_pkg.sv
`default_nettype none

package gpp_pkg;

  // APB slave sequencing, one-hot
  typedef enum logic [1:0] {
    GPP_ST_IDLE = 2'b01,
    GPP_ST_RESP = 2'b10
  } gpp_apb_state_t;

endpackage

`default_nettype wire

//--- tb/gpp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpp_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Device side of the bidirectional pins
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] oe_n,
  input  wire logic [3:0] pu_en,
  // Board drivers
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  // Resolved pad level
  output logic      [3:0] pin_lvl
);
  logic [3:0] last_q = 4'h0;

  // A floating pad toggles so a stale level can never pass as a real one
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!oe_n[i]) pin_lvl[i] = pin_o[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pu_en[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = ~last_q[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    last_q <= pin_lvl;
  end
endmodule

`default_nettype wire

//--- tb/gpp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpp_cfg.svh"

module gpp_top_tb;
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  in_eight_pin;
  logic [3:0]  in_four_pin;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_o;
  logic [3:0]  oe_n;
  logic [3:0]  pu_en;
  logic [3:0]  ext_en;
  logic [3:0]  ext_val;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          checks_done;

  gpp_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_eight_pin(in_eight_pin), .in_four_pin(in_four_pin), .bidir_pin_lvl(pin_lvl),
    .bidir_pin_drv(pin_o), .bidir_pin_oe_n(oe_n), .bidir_pullup_en(pu_en));

  gpp_pin_model u_pins (.clk_sys(clk_sys), .pin_o(pin_o), .oe_n(oe_n), .pu_en(pu_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is seen high; data taken at that edge only
  task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
    chk("read pslverr", 32'h0, {31'h0, err});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write pslverr", 32'h0, {31'h0, err});
  endtask

  // Synchroniser delay is 2 cycles, so settle for 4
  task automatic pins(input logic [7:0] e, input logic [3:0] f, input logic [3:0] en, input logic [3:0] v);
    @(posedge clk_sys);
    in_eight_pin <= e;
    in_four_pin <= f;
    ext_en <= en;
    ext_val <= v;
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    in_eight_pin = 8'h00;
    in_four_pin = 4'h0;
    ext_en = 4'hf;
    ext_val = 4'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("oe_n", 32'hf, {28'h0, oe_n});
    chk("pin_o", 32'h0, {28'h0, pin_o});
    chk("pullup_en", 32'h0, {28'h0, pu_en});
    rchk("dir", `GPP_OFF_BIDIR_DIR, 32'h0);
    rchk("out", `GPP_OFF_BIDIR_OUT, 32'h0);
    rchk("pullup", `GPP_OFF_BIDIR_PULLUP, 32'h0);
    for (int i = 0; i < 2; i++) begin
      pins(i ? 8'h5a : 8'ha5, i ? 4'h6 : 4'h9, 4'hf, i ? 4'h3 : 4'hc);
      rchk("eight", `GPP_OFF_EIGHT_STATE, i ? 32'h5a : 32'ha5);
      rchk("four", `GPP_OFF_FOUR_STATE, i ? 32'h6 : 32'h9);
      rchk("state", `GPP_OFF_BIDIR_STATE, i ? 32'h3 : 32'hc);
    end
    wr(`GPP_OFF_EIGHT_STATE, 32'hff);
    wr(`GPP_OFF_FOUR_STATE, 32'hff);
    rchk("eight", `GPP_OFF_EIGHT_STATE, 32'h5a);
    rchk("four", `GPP_OFF_FOUR_STATE, 32'h6);
    wr(`GPP_OFF_BIDIR_DIR, 32'hf5);
    wr(`GPP_OFF_BIDIR_OUT, 32'hff);
    pins(8'h5a, 4'h6, 4'ha, 4'h0);
    chk("oe_n", 32'ha, {28'h0, oe_n});
    chk("pin_o", 32'hf, {28'h0, pin_o});
    rchk("out", `GPP_OFF_BIDIR_OUT, 32'hf);
    rchk("state", `GPP_OFF_BIDIR_STATE, 32'h5);
    rchk("dir", `GPP_OFF_BIDIR_DIR, 32'h0);
    wr(`GPP_OFF_BIDIR_STATE, 32'h0);
    rchk("state", `GPP_OFF_BIDIR_STATE, 32'h5);
    wr(`GPP_OFF_BIDIR_PULLUP, 32'hff);
    repeat (2) @(posedge clk_sys);
    chk("pullup_en", 32'ha, {28'h0, pu_en});
    rchk("pullup", `GPP_OFF_BIDIR_PULLUP, 32'hf);
    pins(8'h5a, 4'h6, 4'h0, 4'h0);
    wr(`GPP_OFF_BIDIR_OUT, 32'h0);
    rchk("state", `GPP_OFF_BIDIR_STATE, 32'ha);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped rdata", 32'h0, rd);
    chk("unmapped rd err", 32'h1, {31'h0, err});
    apb(1'b1, 12'h018, 32'hf);
    chk("unmapped wr err", 32'h1, {31'h0, err});
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("oe_n", 32'hf, {28'h0, oe_n});
    chk("pullup_en", 32'h0, {28'h0, pu_en});
    rchk("out", `GPP_OFF_BIDIR_OUT, 32'h0);
    rchk("pullup", `GPP_OFF_BIDIR_PULLUP, 32'h0);
    final_report;
  end
endmodule

`default_nettype wire
